/* File: core/pmc_pkg.sv */
package pmc_pkg;
  // bit positions, protection_paging_control
  localparam int unsigned PpcProtEnBit = 0;
  localparam int unsigned PpcWriteProtBit = 16;
  localparam int unsigned PpcPagingEnBit = 31;
  // bit positions, architecture_extension_control
  localparam int unsigned AecLargePageBit = 4;
  localparam int unsigned AecPhysExtBit = 5;
  localparam int unsigned AecGlobalPageBit = 7;
  localparam int unsigned AecFpSaveBit = 9;
  localparam int unsigned AecSimdExcBit = 10;
  localparam int unsigned AecVirtBit = 13;
  localparam int unsigned AecSaferBit = 14;
  localparam int unsigned AecCtxIdBit = 17;
  // bit positions, extended_feature_enables
  localparam int unsigned EfeLongModeEnBit = 8;
  localparam int unsigned EfeLongModeActBit = 10;
  localparam int unsigned EfeNoExecBit = 11;
  // identification leaf 01H feature bits
  localparam int unsigned IdLargePageBit = 3;
  localparam int unsigned IdPhysExtBit = 6;
  localparam int unsigned IdGlobalPageBit = 13;
  localparam int unsigned IdAttrTableBit = 16;
  localparam int unsigned IdWideLargeBit = 17;
  localparam int unsigned IdCtxIdBit = 17;
  // reset values
  localparam logic [63:0] PpcReset = 64'h0000_0000_0000_0000;
  localparam logic [63:0] AecReset = 64'h0000_0000_0000_0000;
  localparam logic [63:0] EfeReset = 64'h0000_0000_0000_0000;
  localparam logic [31:0] IdEdxFeatures = 32'h0003_2048;
  localparam logic [31:0] IdEcxFeatures = 32'h0002_0000;
  // writable bits held by this block
  localparam logic [63:0] PpcWritable = 64'h0000_0000_8001_0001;
  localparam logic [63:0] AecWritable = 64'h0000_0000_0002_66b0;
  localparam logic [63:0] EfeWritable = 64'h0000_0000_0000_0900;
  localparam logic [7:0] TaskPriorityReset = 8'h00;

  typedef enum logic [1:0] {
    PMC_NONE = 2'b00,
    PMC_BIT32 = 2'b01,
    PMC_EXT = 2'b11,
    PMC_LONG = 2'b10
  } pmc_mode_e;

  typedef enum logic [2:0] {
    PMC_W_NONE = 3'h0,
    PMC_W_PPC = 3'h1,
    PMC_W_AEC = 3'h2,
    PMC_W_EFE = 3'h3,
    PMC_W_TPR = 3'h4
  } pmc_wsel_e;

  typedef enum logic [1:0] {
    PMC_INS_NONE = 2'b00,
    PMC_INS_SIMD = 2'b01,
    PMC_INS_EXEMPT = 2'b10,
    PMC_INS_SIMD_EXC = 2'b11
  } pmc_ins_e;
endpackage

/* File: core/pmc_mode_if.sv */
`timescale 1ns/1ps
interface pmc_mode_if;
  logic pagingEn;
  logic physExt;
  logic longModeEn;
  pmc_pkg::pmc_mode_e mode;
  logic longModeAct;
  modport ctrl (output pagingEn, output physExt, output longModeEn, input mode, input longModeAct);
  modport dec (input pagingEn, input physExt, input longModeEn, output mode, output longModeAct);
endinterface

/* File: core/pmc_mode_decode.sv */
`timescale 1ns/1ps
module pmc_mode_decode (
  pmc_mode_if.dec m
);
  always_comb begin
    unique case ({m.pagingEn, m.physExt, m.longModeEn})
      3'b100, 3'b101: m.mode = pmc_pkg::PMC_BIT32;
      3'b110: m.mode = pmc_pkg::PMC_EXT;
      3'b111: m.mode = pmc_pkg::PMC_LONG;
      default: m.mode = pmc_pkg::PMC_NONE;
    endcase
  end
  assign m.longModeAct = m.pagingEn & m.longModeEn;
endmodule

/* File: core/paging_mode_control_regs.sv */
// Overview of operation
// - paging off: addresses pass untranslated, all paging modifier bits ignored
// - paging may be enabled only while protection is enabled
// - paging on, extension clear: 32-bit paging with write-protect, large, global
// - extension set, long mode off: extended paging with write-protect, global, no-exec
// - extension and long mode set: four-level paging with context ids too
// - long-mode-active always equals paging enable AND long mode enable
// - feature register writes never set the long-mode-active bit directly; it follows paging enable AND long mode enable
// - clearing extension while long paging active faults with error code zero
// - paging may be cleared unless context ids are enabled; extension toggles switch 32-bit and extended
// - clearing paging while context ids enabled raises protection fault
// - supervisor writes read-only pages only without write-protect; user never
// - large pages allowed in 32-bit paging only when large-page bit set
// - global translations shared across spaces only when global bit set
// - context ids may be set only while long mode is active
// - fp-save support set: save includes vector state, simd instructions run
// - fp-save support clear: simd instructions fault except exempt ones
// - unmasked simd exception goes to simd fault or invalid-opcode fault
// - extension bit 13 enables virtualization, bit 14 safer mode
// - long mode widens control registers; task priority register accessible
// - identification leaf reports large, extended, global, attribute, wide, ctx
`timescale 1ns/1ps
module paging_mode_control_regs (
  input wire logic clk,
  input wire logic rst,
  input wire logic wrValid,
  input wire logic [2:0] wrSel,
  input wire logic [63:0] wrData,
  input wire logic [1:0] privLevel,
  input wire logic accessWrite,
  input wire logic pageReadOnly,
  input wire logic pageLarge,
  input wire logic pageGlobal,
  input wire logic [1:0] insKind,
  input wire logic simdUnmasked,
  output logic [63:0] protectionPagingControl,
  output logic [63:0] architectureExtensionControl,
  output logic [63:0] extendedFeatureEnables,
  output logic [7:0] taskPriority,
  output logic [1:0] pagingMode,
  output logic translateOn,
  output logic generalProtectionFault,
  output logic invalidOpcodeFault,
  output logic simdFloatFault,
  output logic accessDenied,
  output logic virtEnabled,
  output logic saferEnabled,
  output logic fpStateSaveVector,
  output logic globalShareOk,
  output logic [31:0] idEdx,
  output logic [31:0] idEcx
);

  ////////////////////////////////////////////////////////////////////////////
  logic [63:0] ppc_q;
  logic [63:0] aec_q;
  logic [63:0] efe_q;
  logic [7:0] tpr_q;
  logic [63:0] ppc_d;
  logic [63:0] aec_d;
  logic [63:0] efe_d;
  logic wrFault;
  pmc_pkg::pmc_wsel_e sel;
  pmc_mode_if modeBus ();

  assign sel = pmc_pkg::pmc_wsel_e'(wrSel);
  assign modeBus.pagingEn = ppc_q[pmc_pkg::PpcPagingEnBit];
  assign modeBus.physExt = aec_q[pmc_pkg::AecPhysExtBit];
  assign modeBus.longModeEn = efe_q[pmc_pkg::EfeLongModeEnBit];

  pmc_mode_decode u_decode (
    .m(modeBus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // write checks; a faulting write leaves every register untouched
  always_comb begin
    logic [63:0] unsupported;
    unsupported = 64'h0;
    ppc_d = ppc_q;
    aec_d = aec_q;
    efe_d = efe_q;
    wrFault = 1'b0;
    unsupported[pmc_pkg::AecLargePageBit] = ~pmc_pkg::IdEdxFeatures[pmc_pkg::IdLargePageBit];
    unsupported[pmc_pkg::AecPhysExtBit] = ~pmc_pkg::IdEdxFeatures[pmc_pkg::IdPhysExtBit];
    unsupported[pmc_pkg::AecGlobalPageBit] = ~pmc_pkg::IdEdxFeatures[pmc_pkg::IdGlobalPageBit];
    unsupported[pmc_pkg::AecCtxIdBit] = ~pmc_pkg::IdEcxFeatures[pmc_pkg::IdCtxIdBit];
    if (wrValid) begin
      unique case (sel)
        pmc_pkg::PMC_W_PPC: begin
          ppc_d = wrData & pmc_pkg::PpcWritable;
          if (ppc_d[pmc_pkg::PpcPagingEnBit] && !ppc_d[pmc_pkg::PpcProtEnBit]) begin
            wrFault = 1'b1;
          end
          if (!ppc_d[pmc_pkg::PpcPagingEnBit] && aec_q[pmc_pkg::AecCtxIdBit]) begin
            wrFault = 1'b1;
          end
        end
        pmc_pkg::PMC_W_AEC: begin
          aec_d = wrData & pmc_pkg::AecWritable;
          if (!aec_d[pmc_pkg::AecPhysExtBit] && modeBus.longModeAct) begin
            wrFault = 1'b1;
          end
          if (aec_d[pmc_pkg::AecCtxIdBit] && !aec_q[pmc_pkg::AecCtxIdBit]
              && !modeBus.longModeAct) begin
            wrFault = 1'b1;
          end
          if ((aec_d & unsupported) != 64'h0) begin
            wrFault = 1'b1;
          end
        end
        pmc_pkg::PMC_W_EFE: begin
          // active bit is rebuilt below, so the written value is dropped
          efe_d = wrData & pmc_pkg::EfeWritable;
        end
        default: begin
        end
      endcase
    end
    if (wrFault) begin
      ppc_d = ppc_q;
      aec_d = aec_q;
      efe_d = efe_q;
    end
    efe_d[pmc_pkg::EfeLongModeActBit] =
      ppc_d[pmc_pkg::PpcPagingEnBit] & efe_d[pmc_pkg::EfeLongModeEnBit];
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (rst) begin
      ppc_q <= pmc_pkg::PpcReset;
      aec_q <= pmc_pkg::AecReset;
      efe_q <= pmc_pkg::EfeReset;
    end else begin
      ppc_q <= ppc_d;
      aec_q <= aec_d;
      efe_q <= efe_d;
    end
  end

  // task priority writes take effect only with long mode active
  always_ff @(posedge clk) begin
    if (rst) begin
      tpr_q <= pmc_pkg::TaskPriorityReset;
    end else if (wrValid && sel == pmc_pkg::PMC_W_TPR && modeBus.longModeAct) begin
      tpr_q <= wrData[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (rst) begin
      protectionPagingControl <= pmc_pkg::PpcReset;
      architectureExtensionControl <= pmc_pkg::AecReset;
      extendedFeatureEnables <= pmc_pkg::EfeReset;
      taskPriority <= pmc_pkg::TaskPriorityReset;
      pagingMode <= pmc_pkg::PMC_NONE;
      translateOn <= 1'b0;
      virtEnabled <= 1'b0;
      saferEnabled <= 1'b0;
      fpStateSaveVector <= 1'b0;
      idEdx <= 32'h0;
      idEcx <= 32'h0;
    end else begin
      // outside long mode only the low halves of the protection and extension controls are visible
      protectionPagingControl <= modeBus.longModeAct ? ppc_q : {32'h0, ppc_q[31:0]};
      architectureExtensionControl <= modeBus.longModeAct ? aec_q : {32'h0, aec_q[31:0]};
      extendedFeatureEnables <= efe_q;
      taskPriority <= tpr_q;
      pagingMode <= modeBus.mode;
      translateOn <= modeBus.pagingEn;
      virtEnabled <= aec_q[pmc_pkg::AecVirtBit];
      saferEnabled <= aec_q[pmc_pkg::AecSaferBit];
      fpStateSaveVector <= aec_q[pmc_pkg::AecFpSaveBit];
      idEdx <= pmc_pkg::IdEdxFeatures;
      idEcx <= pmc_pkg::IdEcxFeatures;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fault pulses, one cycle after the causing request
  always_ff @(posedge clk) begin
    if (rst) begin
      generalProtectionFault <= 1'b0;
    end else begin
      generalProtectionFault <= wrFault;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      invalidOpcodeFault <= 1'b0;
      simdFloatFault <= 1'b0;
    end else begin
      invalidOpcodeFault <= 1'b0;
      simdFloatFault <= 1'b0;
      unique case (pmc_pkg::pmc_ins_e'(insKind))
        pmc_pkg::PMC_INS_SIMD: begin
          invalidOpcodeFault <= ~aec_q[pmc_pkg::AecFpSaveBit];
          if (aec_q[pmc_pkg::AecFpSaveBit] && simdUnmasked) begin
            simdFloatFault <= aec_q[pmc_pkg::AecSimdExcBit];
            invalidOpcodeFault <= ~aec_q[pmc_pkg::AecSimdExcBit];
          end
        end
        pmc_pkg::PMC_INS_SIMD_EXC: begin
          simdFloatFault <= simdUnmasked & aec_q[pmc_pkg::AecSimdExcBit];
          invalidOpcodeFault <= simdUnmasked & ~aec_q[pmc_pkg::AecSimdExcBit];
        end
        default: begin
          // exempt instructions never fault on the support bit
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // page access check; modifier bits only matter with paging on
  always_ff @(posedge clk) begin
    if (rst) begin
      accessDenied <= 1'b0;
      globalShareOk <= 1'b0;
    end else if (!modeBus.pagingEn) begin
      accessDenied <= 1'b0;
      globalShareOk <= 1'b0;
    end else begin
      accessDenied <= (accessWrite && pageReadOnly &&
                       (privLevel == 2'h3 || ppc_q[pmc_pkg::PpcWriteProtBit]))
                      || (pageLarge && modeBus.mode == pmc_pkg::PMC_BIT32 &&
                          !aec_q[pmc_pkg::AecLargePageBit]);
      globalShareOk <= pageGlobal && aec_q[pmc_pkg::AecGlobalPageBit];
    end
  end

  // table base loading is left to software; this block holds no table base
endmodule

/* File: verif/pmc_chk.sv */
`timescale 1ns/1ps
module pmc_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic wrValid,
  input wire logic [2:0] wrSel,
  input wire logic [63:0] wrData,
  input wire logic [1:0] insKind,
  input wire logic [63:0] protectionPagingControl,
  input wire logic [63:0] architectureExtensionControl,
  input wire logic [63:0] extendedFeatureEnables,
  input wire logic [1:0] pagingMode,
  input wire logic translateOn,
  input wire logic generalProtectionFault,
  input wire logic invalidOpcodeFault,
  input wire logic virtEnabled,
  input wire logic saferEnabled
);
  // outputs lag writes by two edges, so only judge writes after a quiet gap
  logic [1:0] idleQ;
  logic quiet;
  logic [63:0] ppc, aec, efe;
  logic gpf, w1, w2;
  assign quiet = idleQ == 2'h3;
  assign ppc = protectionPagingControl;
  assign aec = architectureExtensionControl;
  assign efe = extendedFeatureEnables;
  assign gpf = generalProtectionFault;
  assign w1 = quiet && wrValid && wrSel == 3'h1;
  assign w2 = quiet && wrValid && wrSel == 3'h2;
  always_ff @(posedge clk) begin
    if (rst || wrValid) idleQ <= 2'h0;
    else if (!quiet) idleQ <= idleQ + 2'h1;
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  active_bit_a: assert property (efe[10] == (ppc[31] && efe[8]))
    else $error("active bit differs");
  mode_decode_a: assert property (pagingMode == (!ppc[31] ? 2'b00 :
    !aec[5] ? 2'b01 : !efe[8] ? 2'b11 : 2'b10)) else $error("paging mode differs");
  translate_on_a: assert property (translateOn == ppc[31]) else $error("translate flag");
  feature_en_a: assert property ({virtEnabled, saferEnabled} == {aec[13], aec[14]})
    else $error("feature enables differ");
  pe_needed_a: assert property (w1 && wrData[31] && !wrData[0] |-> ##[1:2] gpf)
    else $error("paging without protection accepted");
  ext_clear_a: assert property (w2 && !wrData[5] && ppc[31] && efe[8] |-> ##[1:2] gpf)
    else $error("extension cleared in long paging");
  ctx_clear_a: assert property (w1 && !wrData[31] && aec[17] |-> ##[1:2] gpf)
    else $error("paging cleared with context ids");
  ctx_set_a: assert property (w2 && wrData[17] && !aec[17] && !efe[10] |-> ##[1:2] gpf)
    else $error("context ids set outside long mode");
  pg_off_ok_a: assert property (w1 && !wrData[31] && !aec[17] |=> (!gpf) [*2])
    else $error("paging clear refused");
  simd_off_a: assert property (quiet && insKind == 2'h1 && !aec[9]
    |-> ##[1:2] invalidOpcodeFault) else $error("simd ran without support");
  cover property (pagingMode == 2'b10);
  cover property (gpf);
  cover property (invalidOpcodeFault);
endmodule

bind paging_mode_control_regs pmc_chk u_chk (.clk, .rst, .wrValid, .wrSel, .wrData,
  .insKind, .protectionPagingControl, .architectureExtensionControl, .extendedFeatureEnables,
  .pagingMode, .translateOn, .generalProtectionFault, .invalidOpcodeFault, .virtEnabled,
  .saferEnabled);

/* File: verif/paging_mode_control_regs_tb.sv */
`timescale 1ns/1ps
module paging_mode_control_regs_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wrValid = 1'b0;
  logic [2:0] wrSel = 3'h0;
  logic [63:0] wrData = 64'h0;
  logic [1:0] privLevel = 2'h0;
  logic accessWrite = 1'b0;
  logic pageReadOnly = 1'b0;
  logic [1:0] insKind = 2'h0;
  logic simdUnmasked = 1'b0;
  logic pageLarge = 1'b0;
  logic pageGlobal = 1'b0;
  logic virtEnabled, saferEnabled, fpStateSaveVector, globalShareOk;
  logic [63:0] protectionPagingControl, architectureExtensionControl, extendedFeatureEnables;
  logic [7:0] taskPriority;
  logic [1:0] pagingMode;
  logic translateOn, generalProtectionFault, invalidOpcodeFault, simdFloatFault, accessDenied;
  logic [31:0] idEdx, idEcx;
  int fails = 0;
  int testsRun = 0;
  int cyc = 0;
  logic [63:0] mPpc = 64'h0;
  logic [63:0] mAec = 64'h0;
  logic [63:0] mEfe = 64'h0;
  logic [7:0] mTpr = 8'h0;
  logic seenGp, seenUd, seenXf;
  // select in the top nibble, write data below
  logic [35:0] tbl [16] = '{36'h1_8000_0000, 36'h1_8001_0001, 36'h4_0000_0033,
    36'h2_0000_0020, 36'h2_0000_0000, 36'h2_0000_0020, 36'h2_0002_0020, 36'h1_0000_0001,
    36'h3_0000_0500, 36'h1_8000_0001, 36'h4_0000_005a, 36'h2_0000_0000, 36'h2_0002_62b0,
    36'h1_0000_0001, 36'h2_0000_6620, 36'h1_0000_0001};

  paging_mode_control_regs dut (.clk, .rst, .wrValid, .wrSel, .wrData, .privLevel,
    .accessWrite, .pageReadOnly, .pageLarge, .pageGlobal, .insKind, .simdUnmasked,
    .protectionPagingControl, .architectureExtensionControl, .extendedFeatureEnables,
    .taskPriority, .pagingMode, .translateOn, .generalProtectionFault, .invalidOpcodeFault,
    .simdFloatFault, .accessDenied, .virtEnabled, .saferEnabled, .fpStateSaveVector,
    .globalShareOk, .idEdx, .idEcx);

  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      report_and_stop();
    end
  end
  ////////////////////////////////////////
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", testsRun, fails);
    if (fails == 0 && testsRun > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    testsRun++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // fault outputs are single pulses: sample just after each edge, the first one included
  task automatic idle(input int n);
    seenGp = 1'b0;
    seenUd = 1'b0;
    seenXf = 1'b0;
    repeat (n) begin
      #1;
      seenGp = seenGp | generalProtectionFault;
      seenUd = seenUd | invalidOpcodeFault;
      seenXf = seenXf | simdFloatFault;
      @(posedge clk);
    end
    #1;
  endtask
  task automatic wr(input logic [2:0] s, input logic [63:0] d);
    logic f, long_mode_active;
    long_mode_active = mPpc[31] & mEfe[8];
    f = 1'b0;
    if (s == 3'h1) f = (d[31] & ~d[0]) | (~d[31] & mAec[17]);
    if (s == 3'h2) f = (~d[5] & long_mode_active) | (d[17] & ~mAec[17] & ~long_mode_active);
    if (!f && s == 3'h1) mPpc = d & pmc_pkg::PpcWritable;
    if (!f && s == 3'h2) mAec = d & pmc_pkg::AecWritable;
    if (!f && s == 3'h3) mEfe = d & pmc_pkg::EfeWritable;
    if (s == 3'h4 && long_mode_active) mTpr = d[7:0];
    @(posedge clk);
    wrValid <= 1'b1;
    wrSel <= s;
    wrData <= d;
    insKind <= 2'h0;
    @(posedge clk);
    wrValid <= 1'b0;
    idle(4);
    chk(seenGp, f);
    chk(protectionPagingControl, mPpc);
    chk(architectureExtensionControl, mAec);
    chk(extendedFeatureEnables, mEfe | {53'h0, mPpc[31] & mEfe[8], 10'h0});
    chk(taskPriority, mTpr);
    chk(translateOn, mPpc[31]);
    chk(pagingMode, !mPpc[31] ? 2'b00 : !mAec[5] ? 2'b01 : !mEfe[8] ? 2'b11 : 2'b10);
    chk(fpStateSaveVector, mAec[9]);
    chk({virtEnabled, saferEnabled}, {mAec[13], mAec[14]});
  endtask
  task automatic probe();
    logic [1:0] k;
    logic u, sr;
    k = 2'($urandom);
    u = 1'($urandom);
    @(posedge clk);
    privLevel <= 2'($urandom);
    accessWrite <= 1'($urandom);
    pageReadOnly <= 1'($urandom);
    pageLarge <= 1'($urandom);
    pageGlobal <= 1'($urandom);
    insKind <= k;
    simdUnmasked <= u;
    idle(3);
    sr = (k == 2'h1 && mAec[9]) || k == 2'h3;
    chk(seenUd, (k == 2'h1 && !mAec[9]) || (sr && u && !mAec[10]));
    chk(seenXf, sr && u && mAec[10]);
    chk(accessDenied, mPpc[31] && ((accessWrite && pageReadOnly
      && (privLevel == 2'h3 || mPpc[16])) || (pageLarge && !mAec[5] && !mAec[4])));
    chk(globalShareOk, mPpc[31] && pageGlobal && mAec[7]);
  endtask
  initial begin
    void'($urandom(32'h1ff2));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    idle(3);
    chk(protectionPagingControl | architectureExtensionControl | extendedFeatureEnables, 64'h0);
    chk(idEdx, 32'h0003_2048);
    chk(idEcx, 32'h0002_0000);
    // software side: the table first tries paging without protection, then sets both, and sets the support bits itself
    foreach (tbl[i]) begin
      wr(tbl[i][34:32], {32'h0, tbl[i][31:0]});
      probe();
    end
    repeat (30) begin
      wr(3'($urandom_range(4, 1)), {$urandom, $urandom});
      probe();
    end
    report_and_stop();
  end
endmodule
